//--- shared/pcg_pkg.sv
// Package for the peripheral clock gate and memory light-sleep block
package pcg_pkg;
	// APB geometry
	localparam int unsigned PCG_ADDR_W = 12;
	localparam int unsigned PCG_DATA_W = 32;
	// Register byte offsets
	localparam logic [PCG_ADDR_W-1:0] PCG_OFF_PCLK_GATE = 12'h024;
	localparam logic [PCG_ADDR_W-1:0] PCG_OFF_MEM_PWR = 12'h028;
	// Peripheral clock gate register fields
	localparam int unsigned PCG_BIT_SERIAL_PORT_A = 9;
	localparam int unsigned PCG_BIT_SERIAL_PERIPH_B = 7;
	localparam int unsigned PCG_BIT_SERIAL_PERIPH_A = 6;
	localparam int unsigned PCG_BIT_DMA = 5;
	localparam int unsigned PCG_BIT_PIN_PORT = 0;
	// Memory power control register fields
	localparam int unsigned PCG_BIT_CACHE_LS = 12;
	localparam int unsigned PCG_BIT_BANK3_LS = 11;
	localparam int unsigned PCG_BIT_BANK2_LS = 10;
	localparam int unsigned PCG_BIT_BANK1_LS = 9;
	// Writable bits; everything else reads back zero
	localparam logic [PCG_DATA_W-1:0] PCG_PCLK_MASK = 32'h0000_02E1;
	localparam logic [PCG_DATA_W-1:0] PCG_MEM_MASK = 32'h0000_1E00;
	localparam logic [PCG_DATA_W-1:0] PCG_RST_VAL = 32'h0000_0000;
	// Gated units: 0 pin port, 1 dma, 2 serial periph a, 3 serial periph b, 4 serial port a
	localparam int unsigned PCG_NUM_PERIPH = 5;
	// Memories: 0 bank1, 1 bank2, 2 bank3, 3 cache
	localparam int unsigned PCG_NUM_MEM = 4;
	localparam logic [PCG_NUM_PERIPH-1:0] PCG_CLK_EN_RST = 5'h1F;
	localparam logic [PCG_NUM_MEM-1:0] PCG_MEM_ALL_ON = 4'hF;
	localparam logic [PCG_NUM_MEM-1:0] PCG_MEM_NONE = 4'h0;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [PCG_ADDR_W-1:0] paddr;
		logic [PCG_DATA_W-1:0] pwdata;
	} pcg_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [PCG_DATA_W-1:0] prdata;
	} pcg_apb_rsp_t;

	typedef struct packed {
		logic [PCG_DATA_W-1:0] pclk_gate_reg;
		logic [PCG_DATA_W-1:0] mem_pwr_reg;
		pcg_apb_rsp_t rsp;
		logic [PCG_NUM_PERIPH-1:0] clk_en;
		logic [PCG_NUM_MEM-1:0] light_sleep;
		logic [PCG_NUM_MEM-1:0] rd_grant;
		logic [PCG_NUM_MEM-1:0] clear;
		logic [PCG_NUM_MEM-1:0] pwr_on;
	} pcg_state_t;

	localparam pcg_state_t PCG_STATE_RST = '{
		pclk_gate_reg: PCG_RST_VAL,
		mem_pwr_reg: PCG_RST_VAL,
		rsp: '{pready: 1'b0, pslverr: 1'b0, prdata: PCG_RST_VAL},
		clk_en: PCG_CLK_EN_RST,
		light_sleep: PCG_MEM_NONE,
		rd_grant: PCG_MEM_NONE,
		clear: PCG_MEM_NONE,
		pwr_on: PCG_MEM_ALL_ON
	};
endpackage : pcg_pkg

//--- rtl/pcg_clock_gate.sv
// Peripheral clock gating and memory light-sleep control with APB registers
//
// Operation
// (R1) Disable bit set stops peripheral clock
// (R2) Gating never touches peripheral register contents
// (R3) Serial port a bit9, periph b 7, a 6
// (R4) Standard DMA disable at bit 5
// (R5) Pin port bit0 gates port and pads
// (R6) Software leaves reserved bits; they read zero
// (R7) Cache light sleep bit12 retains, blocks access
// (R8) Cache reset clears despite light sleep
// (R9) Bank3 light sleep bit11 blocks reads
// (R10) Bank2 light sleep bit10 blocks reads
// (R11) Bank1 light sleep bit9 retains, blocks reads
// (R12) RAM reset clears bank despite light sleep
// (R13) Light sleep keeps power; shutdown separate
// (R14) All disable and sleep bits reset zero
// (R15) Glitch-free latch based clock gates
`timescale 1ns/100ps
module pcg_clock_gate (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	// APB slave
	input wire pcg_pkg::pcg_apb_req_t i_apb,
	output pcg_pkg::pcg_apb_rsp_t o_apb,
	// Memory side: index 0 bank1, 1 bank2, 2 bank3, 3 cache
	input wire logic [pcg_pkg::PCG_NUM_MEM-1:0] i_mem_rd_req,
	input wire logic [pcg_pkg::PCG_NUM_MEM-1:0] i_mem_reset,
	input wire logic [pcg_pkg::PCG_NUM_MEM-1:0] i_ram_shutdown_control,
	output logic [pcg_pkg::PCG_NUM_MEM-1:0] o_mem_light_sleep,
	output logic [pcg_pkg::PCG_NUM_MEM-1:0] o_mem_rd_grant,
	output logic [pcg_pkg::PCG_NUM_MEM-1:0] o_mem_clear,
	output logic [pcg_pkg::PCG_NUM_MEM-1:0] o_mem_pwr_on,
	// Peripheral clocks: 0 pin port, 1 dma, 2 serial periph a, 3 b, 4 serial port a
	output logic [pcg_pkg::PCG_NUM_PERIPH-1:0] o_periph_clk_en,
	output logic [pcg_pkg::PCG_NUM_PERIPH-1:0] o_periph_gclk,
	output logic o_pin_pad_gclk
);
	import pcg_pkg::*;

	pcg_state_t st_reg;
	pcg_state_t st_next;
	logic setup_phase;
	logic access_done;
	logic hit_pclk;
	logic hit_mem;

	assign setup_phase = i_apb.psel & ~i_apb.penable;
	assign access_done = i_apb.psel & i_apb.penable & st_reg.rsp.pready;
	assign hit_pclk = (i_apb.paddr == PCG_OFF_PCLK_GATE);
	assign hit_mem = (i_apb.paddr == PCG_OFF_MEM_PWR);

	always_comb begin
		st_next = st_reg;
		// Answer is prepared in setup so pready and prdata leave flops
		st_next.rsp.pready = 1'b0;
		st_next.rsp.pslverr = 1'b0;
		if (setup_phase) begin
			st_next.rsp.pready = 1'b1;
			st_next.rsp.pslverr = ~(hit_pclk | hit_mem);
			if (i_apb.pwrite) begin
				st_next.rsp.prdata = PCG_RST_VAL;
			end else if (hit_pclk) begin
				st_next.rsp.prdata = st_reg.pclk_gate_reg; // [R6]
			end else if (hit_mem) begin
				st_next.rsp.prdata = st_reg.mem_pwr_reg; // [R6]
			end else begin
				st_next.rsp.prdata = PCG_RST_VAL;
			end
		end
		// Writes commit only at the completing access edge
		if (access_done && i_apb.pwrite) begin
			if (hit_pclk) begin
				// Reserved bits are never stored, so they always read zero
				st_next.pclk_gate_reg = i_apb.pwdata & PCG_PCLK_MASK; // [R6] [R3] [R4]
			end
			if (hit_mem) begin
				st_next.mem_pwr_reg = i_apb.pwdata & PCG_MEM_MASK; // [R6]
			end
		end
		// Enables are low-true copies of the disable bits
		st_next.clk_en = ~{st_next.pclk_gate_reg[PCG_BIT_SERIAL_PORT_A],
			st_next.pclk_gate_reg[PCG_BIT_SERIAL_PERIPH_B],
			st_next.pclk_gate_reg[PCG_BIT_SERIAL_PERIPH_A],
			st_next.pclk_gate_reg[PCG_BIT_DMA],
			st_next.pclk_gate_reg[PCG_BIT_PIN_PORT]}; // [R1] [R3] [R4] [R5]
		st_next.light_sleep = {st_next.mem_pwr_reg[PCG_BIT_CACHE_LS],
			st_next.mem_pwr_reg[PCG_BIT_BANK3_LS],
			st_next.mem_pwr_reg[PCG_BIT_BANK2_LS],
			st_next.mem_pwr_reg[PCG_BIT_BANK1_LS]}; // [R7] [R9] [R10] [R11]
		// Power follows the shutdown control only; sleep keeps the array powered
		st_next.pwr_on = ~i_ram_shutdown_control; // [R13]
		// Sleeping or unpowered memories refuse access
		st_next.rd_grant = i_mem_rd_req & ~st_next.light_sleep & st_next.pwr_on; // [R7] [R9] [R10] [R11]
		// A memory reset clears the array whatever the sleep state
		st_next.clear = i_mem_reset; // [R8] [R12]
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			st_reg <= PCG_STATE_RST; // [R14]
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_apb = st_reg.rsp;
	assign o_mem_light_sleep = st_reg.light_sleep;
	assign o_mem_rd_grant = st_reg.rd_grant;
	assign o_mem_clear = st_reg.clear;
	assign o_mem_pwr_on = st_reg.pwr_on;
	assign o_periph_clk_en = st_reg.clk_en;

	// Latch closes while the clock is high, so an enable change cannot clip a pulse.
	// Gating only stops the clock; no peripheral reset is issued, so state survives.
	genvar g;
	generate
		for (g = 0; g < PCG_NUM_PERIPH; g++) begin : g_icg
			logic en_lat;
			always_latch begin
				if (!i_clk_sys) begin
					en_lat <= st_reg.clk_en[g]; // [R15]
				end
			end
			assign o_periph_gclk[g] = i_clk_sys & en_lat; // [R1] [R2] [R15]
			// Latch must hold the registered enable by the time the clock rises
			latch_track_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
				en_lat == st_reg.clk_en[g]) // [R15]
				else $error("clock gate latch lost its enable");
		end
	endgenerate

	// Pads share the port gate
	assign o_pin_pad_gclk = o_periph_gclk[0]; // [R5]

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_sys_rst);

	logic past_valid_reg;
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			past_valid_reg <= 1'b0;
		end else begin
			past_valid_reg <= 1'b1;
		end
	end

	serial_gate_a: assert property (past_valid_reg && access_done && i_apb.pwrite && hit_pclk
		|=> o_periph_clk_en[4] == !$past(i_apb.pwdata[PCG_BIT_SERIAL_PORT_A])) // [R1]
		else $error("serial port a clock enable does not follow write");
	spi_dma_bits_a: assert property (access_done && i_apb.pwrite && hit_pclk
		|=> o_periph_clk_en[3:1] == ~{$past(i_apb.pwdata[7]), $past(i_apb.pwdata[6]),
		$past(i_apb.pwdata[5])}) // [R3] [R4]
		else $error("serial or dma enable bits misplaced");
	pin_port_a: assert property (o_periph_clk_en[0] == !st_reg.pclk_gate_reg[PCG_BIT_PIN_PORT]) // [R5]
		else $error("pin port enable mismatch");
	reserved_zero_a: assert property (o_apb.pready && !o_apb.pslverr |->
		((o_apb.prdata & ~(PCG_PCLK_MASK | PCG_MEM_MASK)) == PCG_RST_VAL)) // [R6]
		else $error("reserved bits read non-zero");
	cache_block_a: assert property (st_next.light_sleep[3] && i_mem_rd_req[3]
		|=> !o_mem_rd_grant[3] && o_mem_light_sleep[3]) // [R7]
		else $error("cache access granted in light sleep");
	bank_block_a: assert property (i_mem_rd_req[2:0] != PCG_MEM_NONE[2:0]
		|=> (o_mem_rd_grant[2:0] & o_mem_light_sleep[2:0]) == PCG_MEM_NONE[2:0]) // [R9] [R10] [R11]
		else $error("bank read granted in light sleep");
	clear_wins_a: assert property (past_valid_reg && $past(i_mem_reset) != PCG_MEM_NONE
		|-> o_mem_clear == $past(i_mem_reset)) // [R8] [R12]
		else $error("memory clear lost");
	sleep_power_a: assert property (1'b1
		|=> o_mem_pwr_on == ~$past(i_ram_shutdown_control)) // [R13]
		else $error("light sleep removed power");
	reset_zero_a: assert property ($fell(i_sys_rst) |-> o_periph_clk_en == PCG_CLK_EN_RST
		&& o_mem_light_sleep == PCG_MEM_NONE) // [R14]
		else $error("bits not zero after reset");
	apb_answer_a: assert property (setup_phase |=> o_apb.pready ##1 !o_apb.pready)
		else $error("apb answer not one cycle");

	// Each enable follows its own disable bit one cycle after the write
	en_pin_port_a: assert property (access_done && i_apb.pwrite && hit_pclk
		|=> o_periph_clk_en[0] == !$past(i_apb.pwdata[PCG_BIT_PIN_PORT])) // [R5]
		else $error("pin port enable does not follow write");
	en_dma_a: assert property (access_done && i_apb.pwrite && hit_pclk
		|=> o_periph_clk_en[1] == !$past(i_apb.pwdata[PCG_BIT_DMA])) // [R4]
		else $error("dma enable does not follow write");
	en_periph_a_a: assert property (access_done && i_apb.pwrite && hit_pclk
		|=> o_periph_clk_en[2] == !$past(i_apb.pwdata[PCG_BIT_SERIAL_PERIPH_A])) // [R3]
		else $error("serial periph a enable does not follow write");
	en_periph_b_a: assert property (access_done && i_apb.pwrite && hit_pclk
		|=> o_periph_clk_en[3] == !$past(i_apb.pwdata[PCG_BIT_SERIAL_PERIPH_B])) // [R3]
		else $error("serial periph b enable does not follow write");
	// Without a write the gates must not move on their own
	en_hold_a: assert property (!(access_done && i_apb.pwrite && hit_pclk)
		|=> $stable(o_periph_clk_en)) // [R1]
		else $error("clock enable changed without a write");

	// Light-sleep outputs follow their control bits
	ls_bank1_a: assert property (access_done && i_apb.pwrite && hit_mem
		|=> o_mem_light_sleep[0] == $past(i_apb.pwdata[PCG_BIT_BANK1_LS])) // [R11]
		else $error("bank1 light sleep does not follow write");
	ls_bank2_a: assert property (access_done && i_apb.pwrite && hit_mem
		|=> o_mem_light_sleep[1] == $past(i_apb.pwdata[PCG_BIT_BANK2_LS])) // [R10]
		else $error("bank2 light sleep does not follow write");
	ls_bank3_a: assert property (access_done && i_apb.pwrite && hit_mem
		|=> o_mem_light_sleep[2] == $past(i_apb.pwdata[PCG_BIT_BANK3_LS])) // [R9]
		else $error("bank3 light sleep does not follow write");
	ls_cache_a: assert property (access_done && i_apb.pwrite && hit_mem
		|=> o_mem_light_sleep[3] == $past(i_apb.pwdata[PCG_BIT_CACHE_LS])) // [R7]
		else $error("cache light sleep does not follow write");
	// A memory reset clears the array but leaves the sleep controls alone
	ls_hold_a: assert property (!(access_done && i_apb.pwrite && hit_mem)
		|=> $stable(o_mem_light_sleep)) // [R7] [R12]
		else $error("light sleep changed without a write");

	// Grants per memory against request, sleep and power
	grant_bank1_a: assert property (1'b1 |=> o_mem_rd_grant[0] == ($past(i_mem_rd_req[0])
		&& !o_mem_light_sleep[0] && !$past(i_ram_shutdown_control[0]))) // [R11]
		else $error("bank1 grant wrong");
	grant_bank2_a: assert property (1'b1 |=> o_mem_rd_grant[1] == ($past(i_mem_rd_req[1])
		&& !o_mem_light_sleep[1] && !$past(i_ram_shutdown_control[1]))) // [R10]
		else $error("bank2 grant wrong");
	grant_bank3_a: assert property (1'b1 |=> o_mem_rd_grant[2] == ($past(i_mem_rd_req[2])
		&& !o_mem_light_sleep[2] && !$past(i_ram_shutdown_control[2]))) // [R9]
		else $error("bank3 grant wrong");
	grant_cache_a: assert property (1'b1 |=> o_mem_rd_grant[3] == ($past(i_mem_rd_req[3])
		&& !o_mem_light_sleep[3] && !$past(i_ram_shutdown_control[3]))) // [R7]
		else $error("cache grant wrong");

	// Clears that arrive during light sleep still reach the array
	clear_cache_a: assert property (o_mem_light_sleep[3] && i_mem_reset[3]
		|=> o_mem_clear[3]) // [R8]
		else $error("cache clear lost in light sleep");
	clear_bank_a: assert property ((o_mem_light_sleep[2:0] & i_mem_reset[2:0]) != PCG_MEM_NONE[2:0]
		|=> (o_mem_clear[2:0] & $past(i_mem_reset[2:0])) == $past(i_mem_reset[2:0])) // [R12]
		else $error("bank clear lost in light sleep");
	// Sleep alone never drops power
	sleep_keeps_a: assert property (o_mem_light_sleep != PCG_MEM_NONE
		&& i_ram_shutdown_control == PCG_MEM_NONE |=> o_mem_pwr_on == PCG_MEM_ALL_ON) // [R13]
		else $error("sleeping memory lost power");

	// Register bus answers
	unmapped_err_a: assert property (setup_phase && !(hit_pclk || hit_mem)
		|=> o_apb.pslverr && o_apb.prdata == PCG_RST_VAL)
		else $error("unmapped access not refused");
	read_pclk_a: assert property (setup_phase && !i_apb.pwrite && hit_pclk
		|=> o_apb.prdata == $past(st_reg.pclk_gate_reg) && !o_apb.pslverr) // [R6]
		else $error("clock gate register read wrong");
	read_mem_a: assert property (setup_phase && !i_apb.pwrite && hit_mem
		|=> o_apb.prdata == $past(st_reg.mem_pwr_reg) && !o_apb.pslverr) // [R6]
		else $error("memory control register read wrong");
	write_rdata_a: assert property (setup_phase && i_apb.pwrite
		|=> o_apb.prdata == PCG_RST_VAL)
		else $error("write answer carries data");
	no_ready_a: assert property (!setup_phase |=> !o_apb.pready)
		else $error("answer without a setup cycle");
	unmapped_wr_a: assert property (access_done && i_apb.pwrite && !(hit_pclk || hit_mem)
		|=> $stable(st_reg.pclk_gate_reg) && $stable(st_reg.mem_pwr_reg)) // [R6]
		else $error("unmapped write changed a register");

	write_pclk_c: cover property (access_done && i_apb.pwrite && hit_pclk);
	write_mem_c: cover property (access_done && i_apb.pwrite && hit_mem);
	blocked_rd_c: cover property (i_mem_rd_req[0] && o_mem_light_sleep[0]);
	clear_sleep_c: cover property (o_mem_clear[3] && o_mem_light_sleep[3]);
endmodule : pcg_clock_gate

//--- testbench/pcg_clock_gate_tb.sv
// Self-checking testbench for the clock gate and light-sleep block
`timescale 1ns/100ps
module pcg_clock_gate_tb;
	import pcg_pkg::*;
	logic i_clk_sys = 1'b0;
	logic i_sys_rst = 1'b1;
	pcg_apb_req_t i_apb = '0;
	pcg_apb_rsp_t o_apb;
	logic [PCG_NUM_MEM-1:0] rd_req = '0, mem_rst = '0, sd = '0;
	logic [PCG_NUM_MEM-1:0] ls, grant, clr, pwr;
	logic [PCG_NUM_PERIPH-1:0] clk_en, gclk;
	logic pad_gclk;
	logic [32:0] exp_q[$];
	logic [31:0] m_pclk = '0, m_mem = '0, rd;
	int n_mismatch = 0, cmp_count = 0;
	always #2 i_clk_sys = ~i_clk_sys;
	pcg_clock_gate dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_apb(i_apb),
		.o_apb(o_apb), .i_mem_rd_req(rd_req), .i_mem_reset(mem_rst),
		.i_ram_shutdown_control(sd), .o_mem_light_sleep(ls), .o_mem_rd_grant(grant),
		.o_mem_clear(clr), .o_mem_pwr_on(pwr), .o_periph_clk_en(clk_en),
		.o_periph_gclk(gclk), .o_pin_pad_gclk(pad_gclk));
	task automatic summarize();
		if (exp_q.size() != 0) begin
			n_mismatch++;
			$display("[ERR] %0t %0d apb answers missing", $time, exp_q.size());
		end
		$display("counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : summarize
	task automatic check(input logic [32:0] got, input logic [32:0] want, input string what);
		cmp_count++;
		if (got !== want) begin
			n_mismatch++;
			$display("[ERR] %0t %s got %h want %h", $time, what, got, want);
		end
	endtask : check
	// Answers are judged against the oldest note, in the order they were issued
	always @(posedge i_clk_sys) begin
		if (i_apb.psel && i_apb.penable && o_apb.pready === 1'b1) begin
			if (exp_q.size() == 0) check(1'b1, 1'b0, "unexpected answer");
			else check({o_apb.pslverr, o_apb.prdata}, exp_q.pop_front(), "apb");
		end
	end
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		logic ok;
		ok = (a == PCG_OFF_PCLK_GATE) || (a == PCG_OFF_MEM_PWR);
		if (wr) exp_q.push_back({~ok, 32'h0000_0000});
		else exp_q.push_back({~ok, (a == PCG_OFF_PCLK_GATE) ? m_pclk : (ok ? m_mem : 32'h0)});
		if (wr && a == PCG_OFF_PCLK_GATE) m_pclk = d & PCG_PCLK_MASK;
		if (wr && a == PCG_OFF_MEM_PWR) m_mem = d & PCG_MEM_MASK;
		i_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge i_clk_sys);
		i_apb.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clk_sys);
			n++;
		end while (o_apb.pready !== 1'b1 && n < 20);
		if (o_apb.pready !== 1'b1) begin
			n_mismatch++;
			$display("[ERR] %0t apb answer timeout", $time);
			summarize();
		end
		i_apb <= '0;
		// Idle edge keeps the next setup off this release
		@(posedge i_clk_sys);
	endtask : apb
	task automatic outs();
		repeat (2) @(posedge i_clk_sys);
		#1;
		check(clk_en, {~m_pclk[9], ~m_pclk[7:5], ~m_pclk[0]}, "clk en");
		check(gclk, {~m_pclk[9], ~m_pclk[7:5], ~m_pclk[0]}, "gated clocks high");
		check(pad_gclk, gclk[0], "pad clock");
		check(ls, m_mem[12:9], "light sleep");
		@(posedge i_clk_sys);
	endtask : outs
	task automatic memrun(input int cnt);
		for (int i = 0; i < cnt; i++) begin
			{rd_req, mem_rst, sd} <= 12'($urandom);
			@(posedge i_clk_sys);
			@(posedge i_clk_sys);
			#1;
			check(grant, 4'(rd_req & ~m_mem[12:9] & ~sd), "read grant");
			check(clr, mem_rst, "memory clear");
			check(pwr, 4'(~sd), "power on");
			@(posedge i_clk_sys);
		end
	endtask : memrun
	initial begin
		void'($urandom(26654));
		repeat (8) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		@(posedge i_clk_sys);
		check(pwr, PCG_MEM_ALL_ON, "power after reset");
		outs();
		apb(1'b0, PCG_OFF_PCLK_GATE, 32'h0);
		apb(1'b0, PCG_OFF_MEM_PWR, 32'h0);
		$display("test reset values done");
		for (int i = 0; i < 36; i++) begin
			rd = (i < 32) ? (32'h1 << i) : ((i == 32) ? 32'hFFFF_FFFF : $urandom);
			apb(1'b1, PCG_OFF_PCLK_GATE, rd);
			apb(1'b1, PCG_OFF_MEM_PWR, ~rd);
			apb(1'b0, PCG_OFF_PCLK_GATE, 32'h0);
			apb(1'b0, PCG_OFF_MEM_PWR, 32'h0);
			outs();
		end
		$display("test field map done");
		apb(1'b1, 12'h02C, 32'hFFFF_FFFF);
		apb(1'b0, 12'h02C, 32'h0);
		apb(1'b0, 12'h020, 32'h0);
		apb(1'b0, PCG_OFF_PCLK_GATE, 32'h0);
		outs();
		$display("test unmapped done");
		for (int k = 0; k < 6; k++) begin
			apb(1'b1, PCG_OFF_MEM_PWR, $urandom);
			outs();
			memrun(20);
		end
		$display("test memory side done");
		apb(1'b1, PCG_OFF_PCLK_GATE, 32'hFFFF_FFFF);
		apb(1'b1, PCG_OFF_MEM_PWR, 32'hFFFF_FFFF);
		i_sys_rst <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		m_pclk = '0;
		m_mem = '0;
		outs();
		apb(1'b0, PCG_OFF_MEM_PWR, 32'h0);
		apb(1'b0, PCG_OFF_PCLK_GATE, 32'h0);
		$display("test mid-run reset done");
		summarize();
	end
endmodule : pcg_clock_gate_tb
